// ---- logic/mwp_pkg.sv ----
/*
 * Constants for the bus matrix write-protection and drive configuration block:
 * register byte addresses, field positions, key value and reset values.
 * Assumes a 32-bit AHB-Lite slave decoding full byte addresses.
 */
`default_nettype none

package mwp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Address map (full byte addresses)
    localparam logic [31:0] MATRIX_BASE = 32'hFFFF_EA00;    // Start of guarded space
    localparam int SPACE_LSB = 9;                           // Guarded span is 512 bytes
    localparam logic [31:0] DRIVE_CFG_ADDR = 32'hFFFF_EB28;
    localparam logic [31:0] PROT_MODE_ADDR = 32'hFFFF_EBE4;
    localparam logic [31:0] PROT_STAT_ADDR = 32'hFFFF_EBE8;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'hFFFF_EC00;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hFFFF_EC04;

    ////////////////////////////////////////////////////////////////////////////
    // Protect mode register fields
    localparam logic [23:0] PROT_KEY = 24'h4D_4154;
    localparam int KEY_LSB = 8;
    localparam int EN_BIT = 0;

    // Protect status register fields
    localparam int VS_BIT = 0;
    localparam int SRC_LSB = 8;
    localparam int SRC_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Drive configuration fields and codes
    localparam int EBI_DRV_LSB = 16;
    localparam int DDR_DRV_BIT = 18;
    localparam logic [1:0] DRV_1V8_HIGH = 2'h0;
    localparam logic [1:0] DRV_3V3_HIGH = 2'h1;
    localparam logic [1:0] DRV_1V8_LOW = 2'h2;
    localparam logic [1:0] DRV_3V3_LOW = 2'h3;
    localparam logic [1:0] EBI_DRV_RST = DRV_3V3_HIGH;
    localparam logic DDR_DRV_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage : mwp_pkg

`default_nettype wire

// ---- logic/mwp_wr_if.sv ----
/*
 * Write channel between the bus front end and the protection core.
 * Assumes one clock; the front end drives the write, the core answers.
 */
`timescale 1ns/10ps
`default_nettype none

interface mwp_wr_if;
    logic wr_valid;             // Data-phase write this cycle
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_allow;             // Write may take effect
    logic prot_en;              // Current protect enable
    logic prot_en_next;
    logic viol_next;
    logic [15:0] src_next;
    logic viol_event;           // Blocked write this cycle

    // Bus front end
    modport front (
        output wr_valid, wr_addr, wr_data,
        input wr_allow, prot_en, prot_en_next, viol_next, src_next, viol_event
    );

    // Protection core
    modport core (
        input wr_valid, wr_addr, wr_data,
        output wr_allow, prot_en, prot_en_next, viol_next, src_next, viol_event
    );
endinterface : mwp_wr_if

`default_nettype wire

// ---- logic/mwp_core.sv ----
/*
 * Write-protection core: protect enable, violation flag and source offset.
 * Assumes the front end presents each write once, in its data phase.
 */
`timescale 1ns/10ps
`default_nettype none

module mwp_core (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Write channel
    mwp_wr_if.core wr
);

    logic prot_en_reg;
    logic viol_reg;
    logic [15:0] src_reg;
    logic is_mode;
    logic guarded;

    ////////////////////////////////////////////////////////////////////////////
    // Address classification
    // whole space guarded except the protect mode register
    assign is_mode = (wr.wr_addr == mwp_pkg::PROT_MODE_ADDR);
    assign guarded = (wr.wr_addr[31:mwp_pkg::SPACE_LSB] == mwp_pkg::MATRIX_BASE[31:mwp_pkg::SPACE_LSB]) && !is_mode;
    assign wr.wr_allow = wr.wr_valid && !(guarded && prot_en_reg);
    assign wr.viol_event = wr.wr_valid && guarded && prot_en_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        wr.prot_en_next = prot_en_reg;
        wr.viol_next = viol_reg;
        wr.src_next = src_reg;
        if (wr.wr_valid && is_mode) begin
            if (wr.wr_data[31:mwp_pkg::KEY_LSB] == mwp_pkg::PROT_KEY) begin
                wr.prot_en_next = wr.wr_data[mwp_pkg::EN_BIT];
            end
            wr.viol_next = 1'b0;
            wr.src_next = 16'h0000;
        end else if (wr.viol_event) begin
            wr.viol_next = 1'b1;
            wr.src_next = {7'h00, wr.wr_addr[mwp_pkg::SPACE_LSB-1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prot_en_reg <= 1'b0;
            viol_reg <= 1'b0;
            src_reg <= 16'h0000;
        end else begin
            prot_en_reg <= wr.prot_en_next;
            viol_reg <= wr.viol_next;
            src_reg <= wr.src_next;
        end
    end

    assign wr.prot_en = prot_en_reg;

endmodule : mwp_core

`default_nettype wire

// ---- logic/mwp_top.sv ----
/*
 * Bus matrix write protection with drive configuration, AHB-Lite slave.
 * Assumes a single AHB-Lite master doing word transfers; zero wait states.
 * Assumes the guarded registers live in other blocks fed by the forward port,
 * and that hready_i is this slave's own hreadyout_o.
 */
// What this block does
// - Correct key write updates protect enable
// - Wrong key leaves protect enable unchanged
// - Key field is write-only, reads zero
// - Protection guards offsets 0x000 to 0x1FC except the mode register at 0x1E4
// - Guarded writes accepted only while unprotected
// - Blocked write sets violation status
// - Protect mode write clears violation status
// - Violation source reports blocked register offset
// - Source field reads zero without violation
// - Two-bit external bus drive code decoded
// - DDR drive bit: zero high, one low
// - External bus drive resets to high
// - External bus voltage resets to 3.3V
`timescale 1ns/10ps
`default_nettype none

module mwp_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Drive configuration
    output logic [1:0] ext_bus_drive_select_o,
    output logic ext_bus_1v8_o,
    output logic ext_bus_low_drive_o,
    output logic ddr_low_drive_o,
    // Protection state and forwarded writes
    output logic prot_enable_o,
    output logic cfg_wr_o,
    output logic [8:0] cfg_offset_o,
    output logic [31:0] cfg_wdata_o,
    // Interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Data phase tracking
    logic dp_wr_reg;
    logic dp_wr_next;
    logic [31:0] dp_addr_reg;
    logic [31:0] dp_addr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic addr_phase;

    // Drive configuration
    logic [1:0] ebi_drv_reg;
    logic [1:0] ebi_drv_next;
    logic ddr_drv_reg;
    logic ddr_drv_next;

    // Interrupt status and mask
    logic irq_stat_reg;
    logic irq_stat_next;
    logic irq_mask_reg;
    logic irq_mask_next;
    logic irq_reg;
    logic irq_next;

    // Forwarded configuration write
    logic cfg_wr_reg;
    logic cfg_wr_next;
    logic [8:0] cfg_off_reg;
    logic [8:0] cfg_off_next;
    logic [31:0] cfg_data_reg;
    logic [31:0] cfg_data_next;

    // Write channel to the protection core
    mwp_wr_if wr ();

    ////////////////////////////////////////////////////////////////////////////
    // Address match, used for both write commit and read mux
    // Full 32-bit compare, so no alias of a register ever matches
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
        hit = (addr == target);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Protection core
    // Holds enable, violation flag and source; decides which writes land
    mwp_core u_core (
        .sys_clk_i (sys_clk_i),
        .rst_i (rst_i),
        .wr (wr)
    );

    // Data-phase write presented to the core; only whole words count
    assign wr.wr_valid = dp_wr_reg;
    assign wr.wr_addr = dp_addr_reg;
    assign wr.wr_data = hwdata_i;

    ////////////////////////////////////////////////////////////////////////////
    // Bus response: always ready, always OKAY
    // Every register is a flip-flop answering in the cycle after the
    // address phase, so no wait state is needed. A refused write is
    // dropped quietly and shows only in the violation and interrupt status, never
    // as an error response that could upset a master mid-sequence.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Valid transfer in its address phase; hready_i keeps a phase that
    // another slave still stretches from being taken twice
    assign addr_phase = hsel_i && htrans_i[1] && hready_i;

    ////////////////////////////////////////////////////////////////////////////
    // Data phase capture
    // Non-word writes are dropped here, so a partial write never reaches
    // the key field or the guarded space and never counts as a violation
    always_comb begin
        dp_wr_next = 1'b0;
        dp_addr_next = dp_addr_reg;
        if (addr_phase) begin
            dp_wr_next = hwrite_i && (hsize_i == mwp_pkg::HSIZE_WORD);
            dp_addr_next = haddr_i;
        end
    end

    // Data-phase flip-flops; reset drops a transfer in flight so no
    // stale write lands once reset is released
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= mwp_pkg::ZERO_WORD;
        end else begin
            dp_wr_reg <= dp_wr_next;
            dp_addr_reg <= dp_addr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive configuration register
    // Only the drive fields are held here; the other bits of this word
    // belong to the block behind the forward port
    always_comb begin
        ebi_drv_next = ebi_drv_reg;
        ddr_drv_next = ddr_drv_reg;
        if (wr.wr_allow && hit(dp_addr_reg, mwp_pkg::DRIVE_CFG_ADDR)) begin
            ebi_drv_next = hwdata_i[mwp_pkg::EBI_DRV_LSB+1:mwp_pkg::EBI_DRV_LSB];
            ddr_drv_next = hwdata_i[mwp_pkg::DDR_DRV_BIT];
        end
    end

    // Drive flip-flops; 3.3V high drive after reset is safe for either
    // memory supply until software has set the range
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ebi_drv_reg <= mwp_pkg::EBI_DRV_RST;
            ddr_drv_reg <= mwp_pkg::DDR_DRV_RST;
        end else begin
            ebi_drv_reg <= ebi_drv_next;
            ddr_drv_reg <= ddr_drv_next;
        end
    end

    assign ext_bus_drive_select_o = ebi_drv_reg;
    assign ext_bus_1v8_o = (ebi_drv_reg == mwp_pkg::DRV_1V8_HIGH) || (ebi_drv_reg == mwp_pkg::DRV_1V8_LOW);
    assign ext_bus_low_drive_o = (ebi_drv_reg == mwp_pkg::DRV_1V8_LOW) || (ebi_drv_reg == mwp_pkg::DRV_3V3_LOW);
    assign ddr_low_drive_o = ddr_drv_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status (write one to clear) and mask
    // Both sit outside the guarded span, so software can acknowledge a
    // violation even while protection is on
    always_comb begin
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (wr.wr_allow && hit(dp_addr_reg, mwp_pkg::IRQ_STAT_ADDR) && hwdata_i[0]) begin
            irq_stat_next = 1'b0;
        end
        // A violation in the clearing cycle still lands
        if (wr.viol_event) begin
            irq_stat_next = 1'b1;
        end
        if (wr.wr_allow && hit(dp_addr_reg, mwp_pkg::IRQ_MASK_ADDR)) begin
            irq_mask_next = hwdata_i[0];
        end
        // Next values keep irq_o in step with the status bit it shows
        irq_next = irq_stat_next && irq_mask_next;
    end

    // Interrupt flip-flops; a registered output cannot glitch while the
    // status and mask decode settles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
        end
    end

    assign irq_o = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Forwarded writes for matrix registers held in other blocks
    // Mode and status are handled here and never forwarded; a blocked
    // write is not forwarded either, so the far block needs no check
    always_comb begin
        cfg_wr_next = 1'b0;
        cfg_off_next = cfg_off_reg;
        cfg_data_next = cfg_data_reg;
        if (wr.wr_allow
            && (dp_addr_reg[31:mwp_pkg::SPACE_LSB] == mwp_pkg::MATRIX_BASE[31:mwp_pkg::SPACE_LSB])
            && !hit(dp_addr_reg, mwp_pkg::PROT_MODE_ADDR)
            && !hit(dp_addr_reg, mwp_pkg::PROT_STAT_ADDR)) begin
            cfg_wr_next = 1'b1;
            cfg_off_next = dp_addr_reg[mwp_pkg::SPACE_LSB-1:0];
            cfg_data_next = hwdata_i;
        end
    end

    // Forward flip-flops; the strobe lasts one cycle, offset and data
    // hold until the next forwarded write
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg_wr_reg <= 1'b0;
            cfg_off_reg <= 9'h000;
            cfg_data_reg <= mwp_pkg::ZERO_WORD;
        end else begin
            cfg_wr_reg <= cfg_wr_next;
            cfg_off_reg <= cfg_off_next;
            cfg_data_reg <= cfg_data_next;
        end
    end

    assign cfg_wr_o = cfg_wr_reg;
    assign cfg_offset_o = cfg_off_reg;
    assign cfg_wdata_o = cfg_data_reg;
    assign prot_enable_o = wr.prot_en;

    ////////////////////////////////////////////////////////////////////////////
    // Read data: sampled from next values so a write just ahead is seen
    // Unmapped addresses and forwarded registers, bar the drive fields, read as zero;
    // their contents are visible only in the blocks that own them
    always_comb begin
        rdata_next = mwp_pkg::ZERO_WORD;
        if (addr_phase && !hwrite_i) begin
            if (hit(haddr_i, mwp_pkg::PROT_MODE_ADDR)) begin
                rdata_next[mwp_pkg::EN_BIT] = wr.prot_en_next;
            end else if (hit(haddr_i, mwp_pkg::PROT_STAT_ADDR)) begin
                rdata_next[mwp_pkg::VS_BIT] = wr.viol_next;
                if (wr.viol_next) begin
                    rdata_next[mwp_pkg::SRC_LSB+mwp_pkg::SRC_W-1:mwp_pkg::SRC_LSB] = wr.src_next;
                end
            end else if (hit(haddr_i, mwp_pkg::DRIVE_CFG_ADDR)) begin
                rdata_next[mwp_pkg::EBI_DRV_LSB+1:mwp_pkg::EBI_DRV_LSB] = ebi_drv_next;
                rdata_next[mwp_pkg::DDR_DRV_BIT] = ddr_drv_next;
            end else if (hit(haddr_i, mwp_pkg::IRQ_STAT_ADDR)) begin
                rdata_next[0] = irq_stat_next;
            end else if (hit(haddr_i, mwp_pkg::IRQ_MASK_ADDR)) begin
                rdata_next[0] = irq_mask_next;
            end
        end
    end

    // Read data flip-flop; zero outside a read data phase, so the bus
    // never sees a stale word
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_reg <= mwp_pkg::ZERO_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign hrdata_o = rdata_reg;

endmodule : mwp_top

`default_nettype wire

// ---- test/mwp_top_assertions.sv ----
/*
 * Checker for mwp_top: bus answer, protect enable, forwarding and drive decode.
 * Assumes it is bound to mwp_top; one clock, synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module mwp_assertions (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Block outputs
    input wire logic [1:0] ext_bus_drive_select_o,
    input wire logic ext_bus_1v8_o,
    input wire logic ext_bus_low_drive_o,
    input wire logic ddr_low_drive_o,
    input wire logic prot_enable_o,
    input wire logic cfg_wr_o,
    input wire logic [8:0] cfg_offset_o,
    input wire logic [31:0] cfg_wdata_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////
    // Track mode writes, key match and reads
    logic take;
    logic mode_w_q;
    logic key_ok_q;
    logic rd_mode_q;
    logic rd_stat_q;
    assign take = hsel_i && htrans_i[1] && hready_i;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_w_q <= 1'b0;
            key_ok_q <= 1'b0;
            rd_mode_q <= 1'b0;
            rd_stat_q <= 1'b0;
        end else begin
            mode_w_q <= take && hwrite_i && hsize_i == mwp_pkg::HSIZE_WORD && haddr_i == mwp_pkg::PROT_MODE_ADDR;
            key_ok_q <= mode_w_q && hwdata_i[31:8] == mwp_pkg::PROT_KEY;
            rd_mode_q <= take && !hwrite_i && haddr_i == mwp_pkg::PROT_MODE_ADDR;
            rd_stat_q <= take && !hwrite_i && haddr_i == mwp_pkg::PROT_STAT_ADDR;
        end
    end

    ////////////////////////////////////////
    property p_bus_okay; hreadyout_o && !hresp_o; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
    property p_key_update; key_ok_q |-> prot_enable_o == $past(hwdata_i[0]); endproperty
    a_key_update: assert property (p_key_update) else $error("keyed write did not set enable");
    property p_prot_hold; $changed(prot_enable_o) |-> key_ok_q; endproperty
    a_prot_hold: assert property (p_prot_hold) else $error("enable moved without key");
    property p_key_read; rd_mode_q |-> hrdata_o[31:8] == 24'h00_0000; endproperty
    a_key_read: assert property (p_key_read) else $error("key field read not zero");
    property p_cfg_space; cfg_wr_o |-> $past(haddr_i[31:9], 2) == mwp_pkg::MATRIX_BASE[31:9]; endproperty
    a_cfg_space: assert property (p_cfg_space) else $error("forward outside guarded space");
    property p_cfg_fwd;
        cfg_wr_o |-> !$past(prot_enable_o) && cfg_wdata_o == $past(hwdata_i)
            && cfg_offset_o == $past(haddr_i[8:0], 2) && cfg_offset_o != 9'h1E4;
    endproperty
    a_cfg_fwd: assert property (p_cfg_fwd) else $error("bad forwarded write");
    property p_src_zero; rd_stat_q && !hrdata_o[0] |-> hrdata_o[23:8] == 16'h0000; endproperty
    a_src_zero: assert property (p_src_zero) else $error("source nonzero without violation");
    property p_1v8; ext_bus_1v8_o == !ext_bus_drive_select_o[0]; endproperty
    a_1v8: assert property (p_1v8) else $error("voltage decode wrong");
    property p_low; ext_bus_low_drive_o == ext_bus_drive_select_o[1]; endproperty
    a_low: assert property (p_low) else $error("drive level decode wrong");
    property p_rst_drive;
        $fell(rst_i) |-> ext_bus_drive_select_o == mwp_pkg::DRV_3V3_HIGH && !ddr_low_drive_o;
    endproperty
    a_rst_drive: assert property (p_rst_drive) else $error("drive not default after reset");
    property p_rst_clean; $fell(rst_i) |-> !prot_enable_o && !irq_o && !cfg_wr_o; endproperty
    a_rst_clean: assert property (p_rst_clean) else $error("protect state not clean after reset");

    // Main scenarios reached
    c_key: cover property (key_ok_q);
    c_fwd: cover property (cfg_wr_o);
    c_irq: cover property (irq_o);
endmodule : mwp_assertions

bind mwp_top mwp_assertions u_mwp_assertions (.*);

`default_nettype wire

// ---- test/tb_matrix_write_protect_and_drive_cfg.sv ----
/*
 * Self-checking bench for mwp_top: reset values, drive codes, protection, interrupt.
 * Assumes a zero-wait AHB-Lite slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_matrix_write_protect_and_drive_cfg;
    localparam logic [31:0] KEY_ON = {mwp_pkg::PROT_KEY, 8'h01};
    localparam logic [31:0] KEY_OFF = {mwp_pkg::PROT_KEY, 8'h00};
    localparam logic [31:0] BAD_ON = {~mwp_pkg::PROT_KEY, 8'h01};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = mwp_pkg::HSIZE_WORD;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready, hresp, bus_1v8, bus_low, ddr_low, prot_en, cfg_wr, irq;
    logic [1:0] drv_sel;
    logic [8:0] cfg_off;
    logic [31:0] hrdata, cfg_wdata, rd;
    int error_cnt = 0;
    int samples_checked = 0;

    // Clock, 10 ns period
    always #5 sys_clk = ~sys_clk;

    mwp_top dut (.sys_clk_i(sys_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .ext_bus_drive_select_o(drv_sel), .ext_bus_1v8_o(bus_1v8),
        .ext_bus_low_drive_o(bus_low), .ddr_low_drive_o(ddr_low), .prot_enable_o(prot_en),
        .cfg_wr_o(cfg_wr), .cfg_offset_o(cfg_off), .cfg_wdata_o(cfg_wdata), .irq_o(irq));

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    // Write, then let one edge pass so the cycle after the data phase is seen
    task automatic wr_look(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        @(posedge sys_clk);
    endtask : wr_look

    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask : do_reset

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////
    task automatic t_defaults();
        chk(32'({ddr_low, bus_low, bus_1v8, drv_sel}), 32'h1, "drive outputs at reset");
        chk(32'({prot_en, irq, cfg_wr}), 32'h0, "protect state at reset");
        chk(32'({hready, hresp}), 32'h2, "bus ready and okay");
        bus(1'b0, mwp_pkg::DRIVE_CFG_ADDR, 32'h0);
        chk(rd, 32'h0001_0000, "drive register at reset");
        bus(1'b0, mwp_pkg::PROT_MODE_ADDR, 32'h0);
        chk(rd, 32'h0, "mode register at reset");
        bus(1'b0, mwp_pkg::PROT_STAT_ADDR, 32'h0);
        chk(rd, 32'h0, "status register at reset");
        $display("defaults test done");
    endtask : t_defaults

    task automatic t_drive();
        logic [31:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {13'h0, i[2:0], 16'h0};
            wr_look(mwp_pkg::DRIVE_CFG_ADDR, v);
            chk(32'({ddr_low, bus_low, bus_1v8, drv_sel}), {27'h0, i[2], i[1], !i[0], i[1:0]}, "drive decode");
            chk(32'({cfg_wr, cfg_off}), {22'h0, 1'b1, 9'h128}, "forwarded drive write");
            chk(cfg_wdata, v, "forwarded drive data");
            bus(1'b0, mwp_pkg::DRIVE_CFG_ADDR, 32'h0);
            chk(rd, v, "drive readback");
        end
        $display("drive test done");
    endtask : t_drive

    task automatic t_protect();
        wr_look(mwp_pkg::PROT_MODE_ADDR, BAD_ON);
        chk(32'(prot_en), 32'h0, "enable after wrong key");
        wr_look(mwp_pkg::PROT_MODE_ADDR, KEY_ON);
        chk(32'(prot_en), 32'h1, "enable after key");
        bus(1'b0, mwp_pkg::PROT_MODE_ADDR, 32'h0);
        chk(rd, 32'h1, "mode read hides key");
        hsize <= 3'h0;
        wr_look(mwp_pkg::PROT_MODE_ADDR, KEY_OFF);
        chk(32'(prot_en), 32'h1, "byte write to mode ignored");
        hsize <= mwp_pkg::HSIZE_WORD;
        hsel <= 1'b0;
        wr_look(mwp_pkg::PROT_MODE_ADDR, KEY_OFF);
        chk(32'(prot_en), 32'h1, "deselected write ignored");
        hsel <= 1'b1;
        wr_look(mwp_pkg::DRIVE_CFG_ADDR, 32'h0001_0000);
        chk(32'({cfg_wr, drv_sel}), 32'h3, "blocked drive write");
        bus(1'b1, mwp_pkg::MATRIX_BASE, 32'h0);
        bus(1'b0, mwp_pkg::PROT_STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0001, "source of lowest offset");
        bus(1'b1, mwp_pkg::MATRIX_BASE + 32'h1FC, 32'h0);
        bus(1'b0, mwp_pkg::PROT_STAT_ADDR, 32'h0);
        chk(rd, 32'h0001_FC01, "source of highest offset");
        wr_look(mwp_pkg::PROT_MODE_ADDR, {~mwp_pkg::PROT_KEY, 8'h00});
        chk(32'(prot_en), 32'h1, "enable kept on wrong key");
        bus(1'b0, mwp_pkg::PROT_STAT_ADDR, 32'h0);
        chk(rd, 32'h0, "status cleared by mode write");
        wr_look(mwp_pkg::PROT_MODE_ADDR, KEY_OFF);
        wr_look(mwp_pkg::DRIVE_CFG_ADDR, 32'h0001_0000);
        chk(32'({prot_en, cfg_wr, drv_sel}), 32'h5, "write accepted when off");
        $display("protect test done");
    endtask : t_protect

    task automatic t_irq();
        bus(1'b1, mwp_pkg::PROT_MODE_ADDR, KEY_ON);
        bus(1'b1, mwp_pkg::IRQ_MASK_ADDR, 32'h0);
        wr_look(mwp_pkg::MATRIX_BASE + 32'h4, 32'h0);
        chk(32'(irq), 32'h0, "masked interrupt");
        bus(1'b0, mwp_pkg::IRQ_STAT_ADDR, 32'h0);
        chk(rd, 32'h1, "interrupt status set");
        wr_look(mwp_pkg::IRQ_MASK_ADDR, 32'h1);
        chk(32'(irq), 32'h1, "unmasked interrupt");
        wr_look(mwp_pkg::IRQ_STAT_ADDR, 32'h1);
        chk(32'(irq), 32'h0, "interrupt cleared");
        bus(1'b0, 32'hFFFF_EC10, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wr_look(mwp_pkg::MATRIX_BASE + 32'h8, 32'h0);
        chk(32'({irq, prot_en}), 32'h3, "state before second reset");
        $display("interrupt test done");
    endtask : t_irq

    ////////////////////////////////////////
    // Main sequence, then a reset in mid-run with protection on
    initial begin
        do_reset();
        t_defaults();
        t_drive();
        t_protect();
        t_irq();
        do_reset();
        t_defaults();
        print_verdict();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
endmodule : tb_matrix_write_protect_and_drive_cfg

`default_nettype wire
